//--- rtl/lsl_pkg.sv
package lsl_pkg;

  // ----------------------------------------------------------------
  // Register bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 16;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_PORT1_IND_CTRL = 12'h06C;
  localparam logic [ADDR_W-1:0] OFS_PORT2_IND_CTRL = 12'h084;
  localparam logic [ADDR_W-1:0] OFS_GLOBAL_CTRL7   = 12'h0A0;
  localparam logic [ADDR_W-1:0] OFS_CHIP_CONFIG    = 12'h0D0;
  localparam logic [ADDR_W-1:0] OFS_IND_STATUS     = 12'h0D4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned PCTL_OVR_LSB    = 12;  // Override field [14:12]
  localparam int unsigned PCTL_OVR_W      = 3;
  localparam int unsigned PCTL_MAN_FIRST  = 0;   // Manual first indicator on
  localparam int unsigned PCTL_MAN_SECOND = 1;   // Manual second indicator on
  localparam int unsigned GCTL_MODE_LSB   = 8;   // Indicator mode [9:8]
  localparam int unsigned GCTL_MODE_W     = 2;
  localparam int unsigned CCR_WIDTH_LSB   = 6;   // Bus width copy [7:6]
  localparam int unsigned CCR_PROM_BIT    = 9;
  localparam int unsigned CCR_ENDIAN_BIT  = 10;
  localparam int unsigned CCR_RSVD_BIT    = 11;  // Reserved strap level

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] PCTL_RST     = 16'h0000;
  localparam logic [DATA_W-1:0] GCTL_RST     = 16'h0000;
  localparam logic [DATA_W-1:0] CCR_RST      = 16'h0000;
  localparam logic [DATA_W-1:0] PCTL_WMASK   = 16'h7003;
  localparam logic [DATA_W-1:0] GCTL_WMASK   = 16'h0300;
  localparam logic [DATA_W-1:0] DATA_ZERO    = 16'h0000;
  localparam logic [PCTL_OVR_W-1:0] OVR_AUTO = 3'h0;

  // ----------------------------------------------------------------
  // Indicator modes
  // ----------------------------------------------------------------
  localparam logic [GCTL_MODE_W-1:0] MODE_SPD = 2'h0;
  localparam logic [GCTL_MODE_W-1:0] MODE_ACT = 2'h1;
  localparam logic [GCTL_MODE_W-1:0] MODE_DPX = 2'h2;
  localparam logic [GCTL_MODE_W-1:0] MODE_DPL = 2'h3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned BLINK_HALF_MS   = 20;
  localparam int unsigned BLINK_HALF_CYC  = BLINK_HALF_MS * (CLK_HZ / 1000);
  localparam int unsigned RESET_MIN_MS    = 10;  // Held by the reset source
  localparam int unsigned SETTLE_CYC      = 4;   // Sync depth plus margin
  localparam int unsigned CNT_W           = 32;
  localparam int unsigned SCNT_W          = 4;

  // ----------------------------------------------------------------
  // Strap sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_SETTLE = 3'b001,
    ST_RUN    = 3'b010,
    ST_PDOWN  = 3'b100
  } lsl_state_t;

endpackage : lsl_pkg

//--- rtl/lsl_sync.sv
`timescale 1ns/1ps
module lsl_sync #(
  parameter int unsigned W = 1
) (
  // Clock
  input  wire logic         clk,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } lsl_sync_t;

  lsl_sync_t s_reg;
  lsl_sync_t s_next;

  // No reset: must keep tracking pins while reset holds them as straps
  always_comb begin
    s_next        = s_reg;
    s_next.meta   = d;
    s_next.stable = s_reg.meta;
  end

  // Two-stage capture
  always_ff @(posedge clk) begin
    s_reg <= s_next;
  end

  assign q = s_reg.stable;

endmodule : lsl_sync

//--- rtl/lsl_port_ind.sv
`timescale 1ns/1ps
module lsl_port_ind
  import lsl_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // Port status
  input  wire logic                   link_up,
  input  wire logic                   act_pulse,
  input  wire logic                   speed_100,
  input  wire logic                   full_duplex,
  // Control
  input  wire logic                   blink_tick,
  input  wire logic [GCTL_MODE_W-1:0] mode,
  input  wire logic [PCTL_OVR_W-1:0]  ovr,
  input  wire logic                   man_first,
  input  wire logic                   man_second,
  // Indicator demand, 1 = lit
  output logic                        first_on,
  output logic                        second_on
);

  typedef struct packed {
    logic act_seen;
    logic act_hold;
    logic phase;
  } lsl_ind_t;

  lsl_ind_t s_reg;
  lsl_ind_t s_next;
  logic     act_on;
  logic     linkact_on;
  logic     auto_first;
  logic     auto_second;

  // Activity is stretched over one blink half-period, one tick interval, so short bursts show
  always_comb begin
    s_next = s_reg;
    if (blink_tick) begin
      s_next.phase    = ~s_reg.phase;
      s_next.act_hold = s_reg.act_seen | act_pulse;
      s_next.act_seen = act_pulse;
    end else if (act_pulse) begin
      s_next.act_seen = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Blink forms: activity alone, link steady with activity blink
  // link and activity
  assign act_on     = s_reg.act_hold & s_reg.phase;
  assign linkact_on = link_up & ~(s_reg.act_hold & s_reg.phase);

  // Mode mapping
  // mode table
  always_comb begin
    auto_first  = link_up;
    auto_second = full_duplex;
    unique case (mode)
      MODE_SPD: begin
        auto_first  = linkact_on;
        auto_second = link_up & speed_100;
      end
      MODE_ACT: begin
        auto_first  = link_up;
        auto_second = act_on;
      end
      MODE_DPX: begin
        auto_first  = linkact_on;
        auto_second = link_up & full_duplex;
      end
      MODE_DPL: begin
        auto_first  = link_up;
        auto_second = link_up & full_duplex;
      end
    endcase
  end

  // Override hands the pins to software
  // override select
  assign first_on  = (ovr == OVR_AUTO) ? auto_first  : man_first;
  assign second_on = (ovr == OVR_AUTO) ? auto_second : man_second;

endmodule : lsl_port_ind

//--- rtl/lsl_top.sv
// Functional notes
// - Link steady, activity blinks, combined both
// - Speed indicator lit at 100, off at 10
// - Duplex indicator lit full, off half
// - Indicator pins are active low
// - Override 000 automatic, else software drives
// - Global two-bit mode field, default 00
// - Bus width strap latched into config 7:6
// - Byte order strap latched into config 10
// - Prom select strap latched into config 9
// - Shared strap pins input during reset, then driven; prom select strap pin is never driven
// - Re-latch straps after every reset or power-down
`timescale 1ns/1ps
module lsl_top
  import lsl_pkg::*;
#(
  parameter int unsigned BLINK_CYCLES = BLINK_HALF_CYC
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // Port 1 status
  input  wire logic              p1_link_up,
  input  wire logic              p1_act,
  input  wire logic              p1_speed_100,
  input  wire logic              p1_full_duplex,
  // Port 2 status
  input  wire logic              p2_link_up,
  input  wire logic              p2_act,
  input  wire logic              p2_speed_100,
  input  wire logic              p2_full_duplex,
  // Power management
  input  wire logic              power_down,
  // Shared indicator and strap pins
  input  wire logic              port1_first_indicator_in,
  output logic                   port1_first_indicator_out,
  output logic                   port1_first_indicator_oe,
  input  wire logic              port1_second_indicator_in,
  output logic                   port1_second_indicator_out,
  output logic                   port1_second_indicator_oe,
  input  wire logic              port2_first_indicator_in,
  output logic                   port2_first_indicator_out,
  output logic                   port2_first_indicator_oe,
  input  wire logic              port2_second_indicator_in,
  output logic                   port2_second_indicator_out,
  output logic                   port2_second_indicator_oe,
  // Strap-only pin
  input  wire logic              wake_or_prom_select_strap,
  // Latched host interface options
  output logic [1:0]             bus_width_cfg,
  output logic                   little_endian_cfg,
  output logic                   prom_present_cfg,
  output logic                   straps_valid
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    lsl_state_t        state;
    logic [SCNT_W-1:0] settle_cnt;
    logic [CNT_W-1:0]  blink_cnt;
    logic              tick;
    logic [DATA_W-1:0] p1_ctrl;
    logic [DATA_W-1:0] p2_ctrl;
    logic [DATA_W-1:0] gctl;
    logic [DATA_W-1:0] chip_config_register;
    logic [DATA_W-1:0] rdata;
    logic [3:0]        pin_out;
    logic [3:0]        pin_oe;
    logic              valid;
  } lsl_regs_t;

  lsl_regs_t s_reg;
  lsl_regs_t s_next;

  // Pin order inside pin_out, pin_oe and strap_sync
  localparam int unsigned PIN_P1F = 0;
  localparam int unsigned PIN_P1S = 1;
  localparam int unsigned PIN_P2F = 2;
  localparam int unsigned PIN_P2S = 3;
  localparam int unsigned PIN_PROM = 4;

  logic [4:0] strap_raw;
  logic [4:0] strap_sync;
  logic       p1_first_on;
  logic       p1_second_on;
  logic       p2_first_on;
  logic       p2_second_on;
  logic [3:0] lit;

  // ----------------------------------------------------------------
  // Strap pin synchronisers
  // ----------------------------------------------------------------
  assign strap_raw = {wake_or_prom_select_strap,
                      port2_second_indicator_in,
                      port2_first_indicator_in,
                      port1_second_indicator_in,
                      port1_first_indicator_in};

  lsl_sync #(
    .W (5)
  ) u_strap_sync (
    .clk (clk),
    .d   (strap_raw),
    .q   (strap_sync)
  );

  // ----------------------------------------------------------------
  // Per-port indicator logic
  // ----------------------------------------------------------------
  lsl_port_ind u_port1 (
    .clk         (clk),
    .rst_n       (rst_n),
    .link_up     (p1_link_up),
    .act_pulse   (p1_act),
    .speed_100   (p1_speed_100),
    .full_duplex (p1_full_duplex),
    .blink_tick  (s_reg.tick),
    .mode        (s_reg.gctl[GCTL_MODE_LSB +: GCTL_MODE_W]),
    .ovr         (s_reg.p1_ctrl[PCTL_OVR_LSB +: PCTL_OVR_W]),
    .man_first   (s_reg.p1_ctrl[PCTL_MAN_FIRST]),
    .man_second  (s_reg.p1_ctrl[PCTL_MAN_SECOND]),
    .first_on    (p1_first_on),
    .second_on   (p1_second_on)
  );

  lsl_port_ind u_port2 (
    .clk         (clk),
    .rst_n       (rst_n),
    .link_up     (p2_link_up),
    .act_pulse   (p2_act),
    .speed_100   (p2_speed_100),
    .full_duplex (p2_full_duplex),
    .blink_tick  (s_reg.tick),
    .mode        (s_reg.gctl[GCTL_MODE_LSB +: GCTL_MODE_W]),
    .ovr         (s_reg.p2_ctrl[PCTL_OVR_LSB +: PCTL_OVR_W]),
    .man_first   (s_reg.p2_ctrl[PCTL_MAN_FIRST]),
    .man_second  (s_reg.p2_ctrl[PCTL_MAN_SECOND]),
    .first_on    (p2_first_on),
    .second_on   (p2_second_on)
  );

  assign lit = {p2_second_on, p2_first_on, p1_second_on, p1_first_on};

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    s_next       = s_reg;
    s_next.tick  = 1'b0;
    s_next.rdata = DATA_ZERO;

    // Shared blink time base for both ports keeps them in step
    if (s_reg.blink_cnt >= CNT_W'(BLINK_CYCLES - 1)) begin
      s_next.blink_cnt = '0;
      s_next.tick      = 1'b1;
    end else begin
      s_next.blink_cnt = s_reg.blink_cnt + CNT_W'(1);
    end

    // Strap sequencer
    unique case (s_reg.state)
      ST_SETTLE: begin
        s_next.pin_oe = '0;
        s_next.pin_out = '1;
        if (power_down) begin
          s_next.state = ST_PDOWN;
          s_next.settle_cnt = '0;
        end else if (s_reg.settle_cnt >= SCNT_W'(SETTLE_CYC - 1)) begin
          // Latch once the synchronisers hold the released pin levels
          // bus width strap
          s_next.chip_config_register[CCR_WIDTH_LSB +: 2] = {2{strap_sync[PIN_P1F]}};
          s_next.chip_config_register[CCR_ENDIAN_BIT]     = strap_sync[PIN_P2F];
          s_next.chip_config_register[CCR_PROM_BIT]       = strap_sync[PIN_PROM];
          s_next.chip_config_register[CCR_RSVD_BIT]       = strap_sync[PIN_P1S];
          s_next.valid = 1'b1;
          s_next.state = ST_RUN;
        end else begin
          s_next.settle_cnt = s_reg.settle_cnt + SCNT_W'(1);
        end
      end
      ST_RUN: begin
        s_next.pin_oe = '1;
        s_next.pin_out = ~lit;
        if (power_down) begin
          s_next.state  = ST_PDOWN;
          s_next.pin_oe = '0;
          s_next.pin_out = '1;
        end
      end
      ST_PDOWN: begin
        // Pins float back to their pulls so the next latch sees straps
        s_next.pin_oe = '0;
        s_next.pin_out = '1;
        s_next.settle_cnt = '0;
        if (!power_down) begin
          s_next.state = ST_SETTLE;
          s_next.valid = 1'b0;
        end
      end
      default: begin
        s_next.state = ST_SETTLE;
        s_next.settle_cnt = '0;
        s_next.pin_oe = '0;
        s_next.pin_out = '1;
      end
    endcase

    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_PORT1_IND_CTRL: s_next.p1_ctrl = reg_wdata & PCTL_WMASK;
        OFS_PORT2_IND_CTRL: s_next.p2_ctrl = reg_wdata & PCTL_WMASK;
        OFS_GLOBAL_CTRL7:   s_next.gctl    = reg_wdata & GCTL_WMASK;
        default:            s_next.rdata   = DATA_ZERO;
      endcase
    end

    // Register reads, data in the following cycle
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_PORT1_IND_CTRL: s_next.rdata = s_reg.p1_ctrl;
        OFS_PORT2_IND_CTRL: s_next.rdata = s_reg.p2_ctrl;
        OFS_GLOBAL_CTRL7:   s_next.rdata = s_reg.gctl;
        OFS_CHIP_CONFIG:    s_next.rdata = s_reg.chip_config_register;
        OFS_IND_STATUS:     s_next.rdata = {11'h000, s_reg.valid, lit};
        default:            s_next.rdata = DATA_ZERO;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // reset restarts latch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg.state      <= ST_SETTLE;
      s_reg.settle_cnt <= '0;
      s_reg.blink_cnt  <= '0;
      s_reg.tick       <= 1'b0;
      s_reg.p1_ctrl    <= PCTL_RST;
      s_reg.p2_ctrl    <= PCTL_RST;
      s_reg.gctl       <= GCTL_RST;
      s_reg.chip_config_register        <= CCR_RST;
      s_reg.rdata      <= DATA_ZERO;
      s_reg.pin_out    <= '1;
      s_reg.pin_oe     <= '0;
      s_reg.valid      <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata                  = s_reg.rdata;
  assign port1_first_indicator_out  = s_reg.pin_out[PIN_P1F];
  assign port1_first_indicator_oe   = s_reg.pin_oe[PIN_P1F];
  assign port1_second_indicator_out = s_reg.pin_out[PIN_P1S];
  assign port1_second_indicator_oe  = s_reg.pin_oe[PIN_P1S];
  assign port2_first_indicator_out  = s_reg.pin_out[PIN_P2F];
  assign port2_first_indicator_oe   = s_reg.pin_oe[PIN_P2F];
  assign port2_second_indicator_out = s_reg.pin_out[PIN_P2S];
  assign port2_second_indicator_oe  = s_reg.pin_oe[PIN_P2S];
  assign bus_width_cfg              = s_reg.chip_config_register[CCR_WIDTH_LSB +: 2];
  assign little_endian_cfg          = s_reg.chip_config_register[CCR_ENDIAN_BIT];
  assign prom_present_cfg           = s_reg.chip_config_register[CCR_PROM_BIT];
  assign straps_valid               = s_reg.valid;

endmodule : lsl_top

//--- dv/lsl_top_asserts.sv
`timescale 1ns/1ps
module lsl_top_asserts
  import lsl_pkg::*;
(
  // Clock, reset, register writes
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  // Port status
  input wire logic              p1_link_up,
  input wire logic              p1_speed_100,
  input wire logic              p2_link_up,
  input wire logic              p2_full_duplex,
  input wire logic              power_down,
  // Pins
  input wire logic              port1_first_indicator_in,
  input wire logic              port1_first_indicator_out,
  input wire logic              port1_first_indicator_oe,
  input wire logic              port1_second_indicator_out,
  input wire logic              port1_second_indicator_oe,
  input wire logic              port2_first_indicator_in,
  input wire logic              port2_first_indicator_oe,
  input wire logic              port2_second_indicator_out,
  input wire logic              port2_second_indicator_oe,
  input wire logic              wake_or_prom_select_strap,
  // Latched options
  input wire logic [1:0]        bus_width_cfg,
  input wire logic              little_endian_cfg,
  input wire logic              prom_present_cfg,
  input wire logic              straps_valid
);
  // ------------------------------------------------------------
  // Shadow of the control fields, so expectations need no probe
  // ------------------------------------------------------------
  logic [1:0] mode_q;
  logic [2:0] ovr1_q;
  logic       man1_q;
  logic [3:0] oe_v;
  assign oe_v = {port1_first_indicator_oe, port1_second_indicator_oe,
                 port2_first_indicator_oe, port2_second_indicator_oe};
  // Mirror writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= MODE_SPD;
      ovr1_q <= OVR_AUTO;
      man1_q <= 1'b0;
    end else if (reg_wr && reg_addr == OFS_GLOBAL_CTRL7) begin
      mode_q <= reg_wdata[9:8];
    end else if (reg_wr && reg_addr == OFS_PORT1_IND_CTRL) begin
      ovr1_q <= reg_wdata[14:12];
      man1_q <= reg_wdata[0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence latch_s;
    $rose(straps_valid) && !power_down;
  endsequence
  sequence run_s;
    $past(port1_second_indicator_oe) && port1_second_indicator_oe;
  endsequence
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  pins_released_a: assert property (!straps_valid |-> oe_v == 4'h0)
    else $error("pin driven before straps latched");
  pins_driven_a: assert property (latch_s |=> oe_v == 4'hF)
    else $error("pins not driven after latch");
  width_latch_a: assert property ($rose(straps_valid) |->
    bus_width_cfg == {2{port1_first_indicator_in}}) else $error("bus width latch wrong");
  endian_latch_a: assert property ($rose(straps_valid) |->
    little_endian_cfg == port2_first_indicator_in) else $error("byte order latch wrong");
  prom_latch_a: assert property ($rose(straps_valid) |->
    prom_present_cfg == wake_or_prom_select_strap) else $error("prom latch wrong");
  cfg_hold_a: assert property (straps_valid && $past(straps_valid) |->
    $stable({bus_width_cfg, little_endian_cfg, prom_present_cfg})) else $error("cfg moved");
  speed_ind_a: assert property (run_s ##0 $past(ovr1_q) == OVR_AUTO
    && $past(mode_q) == MODE_SPD |-> port1_second_indicator_out
    == !($past(p1_link_up) && $past(p1_speed_100))) else $error("speed indicator wrong");
  duplex_ind_a: assert property ($past(port2_second_indicator_oe)
    && port2_second_indicator_oe && $past(mode_q[1]) |-> port2_second_indicator_out
    == !($past(p2_link_up) && $past(p2_full_duplex))) else $error("duplex indicator wrong");
  link_ind_a: assert property (run_s ##0 $past(ovr1_q) == OVR_AUTO
    && $past(mode_q[0]) && port1_first_indicator_oe |->
    port1_first_indicator_out == !$past(p1_link_up)) else $error("link indicator wrong");
  manual_ovr_a: assert property (run_s ##0 $past(ovr1_q) != OVR_AUTO
    |-> port1_first_indicator_out == !$past(man1_q)) else $error("manual drive wrong");
endmodule : lsl_top_asserts

bind lsl_top lsl_top_asserts i_lsl_top_asserts (.*);

//--- dv/lsl_board.sv
`timescale 1ns/1ps
module lsl_board (
  // Strap resistor choices
  input wire logic width_hi,
  input wire logic endian_hi,
  input wire logic prom_hi,
  // Device pin drives
  input wire logic p1f_oe,
  input wire logic p1f_out,
  input wire logic p1s_oe,
  input wire logic p1s_out,
  input wire logic p2f_oe,
  input wire logic p2f_out,
  input wire logic p2s_oe,
  input wire logic p2s_out,
  // Resolved pin levels
  output logic     p1f_pin,
  output logic     p1s_pin,
  output logic     p2f_pin,
  output logic     p2s_pin,
  output logic     prom_pin
);
  // ------------------------------------------------------------
  // Released pins fall to their resistor, never to a stale drive
  // ------------------------------------------------------------
  // width and order resistors
  assign p1f_pin = p1f_oe ? p1f_out : width_hi;
  assign p2f_pin = p2f_oe ? p2f_out : endian_hi;
  assign p1s_pin = p1s_oe ? p1s_out : 1'b1;
  assign p2s_pin = p2s_oe ? p2s_out : 1'b1;
  assign prom_pin = prom_hi;
endmodule : lsl_board

//--- dv/lsl_top_bench.sv
`timescale 1ns/1ps
module lsl_top_bench;
  import lsl_pkg::*;
  localparam int unsigned BLINK = 8;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, power_down = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0, reg_rdata;
  logic p1_link_up = 1'b0, p1_act = 1'b0, p1_speed_100 = 1'b0, p1_full_duplex = 1'b0;
  logic p2_link_up = 1'b0, p2_act = 1'b0, p2_speed_100 = 1'b0, p2_full_duplex = 1'b0;
  logic s_w = 1'b1, s_e = 1'b1, s_p = 1'b0;
  logic port1_first_indicator_in, port1_first_indicator_out, port1_first_indicator_oe;
  logic port1_second_indicator_in, port1_second_indicator_out, port1_second_indicator_oe;
  logic port2_first_indicator_in, port2_first_indicator_out, port2_first_indicator_oe;
  logic port2_second_indicator_in, port2_second_indicator_out, port2_second_indicator_oe;
  logic wake_or_prom_select_strap, little_endian_cfg, prom_present_cfg, straps_valid;
  logic [1:0] bus_width_cfg;
  logic [3:0] oe_v;
  int miscompares = 0;
  int n_tests = 0;
  assign oe_v = {port1_first_indicator_oe, port1_second_indicator_oe,
                 port2_first_indicator_oe, port2_second_indicator_oe};
  // Clock at 200 MHz
  always #2.5 clk = ~clk;
  lsl_top #(.BLINK_CYCLES(BLINK)) i_lsl_top (.*);
  lsl_board i_lsl_board (
    .width_hi(s_w), .endian_hi(s_e), .prom_hi(s_p),
    .p1f_oe(port1_first_indicator_oe), .p1f_out(port1_first_indicator_out),
    .p1s_oe(port1_second_indicator_oe), .p1s_out(port1_second_indicator_out),
    .p2f_oe(port2_first_indicator_oe), .p2f_out(port2_first_indicator_out),
    .p2s_oe(port2_second_indicator_oe), .p2s_out(port2_second_indicator_out),
    .p1f_pin(port1_first_indicator_in), .p1s_pin(port1_second_indicator_in),
    .p2f_pin(port2_first_indicator_in), .p2s_pin(port2_second_indicator_in),
    .prom_pin(wake_or_prom_select_strap));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
    @(posedge clk);
    #1;
    chk(reg_rdata, DATA_ZERO);
  endtask : rd
  // Bounded wait for the strap latch
  task automatic wait_valid();
    int k;
    k = 0;
    repeat (2) @(posedge clk);
    while (straps_valid !== 1'b1 && k < 20) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (k == 20) begin
      miscompares++;
      summarize();
    end
  endtask : wait_valid
  task automatic rst_seq(input logic w, input logic e, input logic p);
    @(posedge clk);
    s_w <= w;
    s_e <= e;
    s_p <= p;
    rst_n <= 1'b0;
    // Reset source holds the line low
    repeat (6) @(posedge clk);
    chk({12'h0, oe_v}, 16'h0000);
    rst_n <= 1'b1;
    wait_valid();
    chk({13'h0, bus_width_cfg, little_endian_cfg}, {13'h0, w, w, e});
    chk({15'h0, prom_present_cfg}, {15'h0, p});
    @(posedge clk);
    #1;
    chk({12'h0, oe_v}, 16'h000F);
    rd(OFS_CHIP_CONFIG, {4'h0, 1'b1, e, p, 1'b0, w, w, 6'h00});
  endtask : rst_seq
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic e1, e2;
    int lo1, lo2;
    for (int i = 0; i < 8; i++) rst_seq(i[0], i[1], i[2]);
    rd(OFS_GLOBAL_CTRL7, GCTL_RST);
    rd(OFS_PORT1_IND_CTRL, PCTL_RST);
    wr(OFS_CHIP_CONFIG, 16'hFFFF);
    rd(OFS_CHIP_CONFIG, 16'h0EC0);
    rd(12'h0FE, DATA_ZERO);
    @(posedge clk);
    p1_link_up <= 1'b1;
    p2_link_up <= 1'b1;
    // Every mode, both speeds and duplexes
    for (int m = 0; m < 4; m++) begin
      for (int v = 0; v < 2; v++) begin
        wr(OFS_GLOBAL_CTRL7, {6'h0, m[1:0], 8'h00});
        p1_speed_100 <= v[0];
        p1_full_duplex <= !v[0];
        p2_speed_100 <= !v[0];
        p2_full_duplex <= v[0];
        repeat (3) @(posedge clk);
        #1;
        e1 = (m == 0) ? !v[0] : (m == 1) ? 1'b1 : v[0];
        e2 = (m == 0) ? v[0] : (m == 1) ? 1'b1 : !v[0];
        chk({port1_first_indicator_out, port1_second_indicator_out}, {1'b0, e1});
        chk({port2_first_indicator_out, port2_second_indicator_out}, {1'b0, e2});
      end
    end
    @(posedge clk);
    p1_link_up <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk({port1_first_indicator_out, port1_second_indicator_out}, 16'h0003);
    @(posedge clk);
    p1_link_up <= 1'b1;
    // Steady traffic: mode 1 then mode 0
    for (int j = 0; j < 2; j++) begin
      wr(OFS_GLOBAL_CTRL7, j ? 16'h0000 : 16'h0100);
      p1_act <= 1'b1;
      lo1 = 0;
      lo2 = 0;
      repeat (48) begin
        @(posedge clk);
        #1;
        lo1 += !port1_first_indicator_out;
        lo2 += !port1_second_indicator_out;
      end
      if (j == 0) chk({15'h0, lo1 == 48 && lo2 > 0 && lo2 < 48}, 16'h0001);
      else chk({15'h0, lo1 > 0 && lo1 < 48 && lo2 == 48}, 16'h0001);
    end
    @(posedge clk);
    p1_act <= 1'b0;
    // Host control of the pins
    wr(OFS_PORT1_IND_CTRL, 16'h1001);
    repeat (2) @(posedge clk);
    #1;
    chk({port1_first_indicator_out, port1_second_indicator_out}, 16'h0001);
    wr(OFS_PORT1_IND_CTRL, 16'hFFFE);
    rd(OFS_PORT1_IND_CTRL, 16'h7002);
    #1;
    chk({port1_first_indicator_out, port1_second_indicator_out}, 16'h0002);
    rd(OFS_IND_STATUS, 16'h0016);
    wr(OFS_PORT1_IND_CTRL, PCTL_RST);
    // Power-down releases pins and relatches
    @(posedge clk);
    power_down <= 1'b1;
    s_w <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk({11'h0, straps_valid, oe_v}, 16'h0010);
    @(posedge clk);
    power_down <= 1'b0;
    wait_valid();
    chk({14'h0, bus_width_cfg}, 16'h0000);
    summarize();
  end
endmodule : lsl_top_bench
